// ---- src/tli_pkg.sv ----
// Purpose: shared constants and carrier types of the interrupt logic
// Assumes: one 10 MHz clock, registers on a plain strobe port
// Notes:   offsets are word indices on the register port
package tli_pkg;
  // register offsets
  localparam logic [3:0] REG_CTRL  = 4'h0; // mode, spacing, power fail
  localparam logic [3:0] REG_MASK  = 4'h1; // controller level mask
  localparam logic [3:0] REG_BASEL = 4'h2; // vector block base, low
  localparam logic [3:0] REG_BASEH = 4'h3; // vector block base, high
  localparam logic [3:0] REG_LOWP  = 4'h4; // lowest priority level
  localparam logic [3:0] REG_EOI   = 4'h5; // write: end of service
  localparam logic [3:0] REG_POLL  = 4'h6; // read: poll status
  localparam logic [3:0] REG_DMASK = 4'h7; // direct restart masks
  localparam logic [3:0] REG_INSV  = 4'h8; // read: levels in service
  localparam logic [3:0] REG_PEND  = 4'h9; // read: pending requests
  // control and poll status fields
  localparam int CTRL_MODE = 0;  // two bits, mode select
  localparam int CTRL_WIDE = 2;  // 1 = 8-byte spacing
  localparam int CTRL_PF   = 3;  // route power fail onto trap
  localparam int POLL_ANY  = 7;  // poll status: request present
  // reset value and fixed lowest level
  localparam logic [2:0] LOWP_RST = 3'h7;
  localparam logic [2:0] LVL_TOP  = 3'h7;
  // fixed call addresses of the direct inputs
  localparam logic [15:0] VEC_TRAP = 16'h0024;
  localparam logic [15:0] VEC_R75  = 16'h003c;
  localparam logic [15:0] VEC_R65  = 16'h0034;
  localparam logic [15:0] VEC_R55  = 16'h002c;
  // acknowledge source codes from the processor
  localparam logic [2:0] ACK_TRAP = 3'h0;
  localparam logic [2:0] ACK_R75  = 3'h1;
  localparam logic [2:0] ACK_R65  = 3'h2;
  localparam logic [2:0] ACK_R55  = 3'h3;
  localparam logic [2:0] ACK_CTL  = 3'h4;
  // controller modes
  typedef enum logic [1:0] {
    TLI_NESTED, TLI_ROTATE, TLI_SPECIFIC, TLI_POLLED
  } tli_mode_t;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tli_bus_t;
  // processor acknowledge
  typedef struct packed {
    logic       stb;
    logic [2:0] src;
  } tli_ack_t;
  // vector handed back
  typedef struct packed {
    logic        vld;
    logic [15:0] addr;
  } tli_vec_t;
endpackage : tli_pkg

// ---- src/tli_prio.sv ----
// Purpose: rotating priority pick over eight request bits
// Assumes: lowp names the lowest ranked level
// Notes:   rank 0 is the strongest; purely combinational
`timescale 1ns/1ns
`default_nettype none
module tli_prio (
  input  wire logic [7:0] req,   // candidate bits
  input  wire logic [2:0] lowp,  // lowest priority level
  output logic            any,   // some bit set
  output logic [2:0]      lvl,   // winning level
  output logic [2:0]      rank   // its rank from the top
);
  import tli_pkg::*;
  // scan from the level after lowp, first hit wins
  always_comb begin
    logic [2:0] idx;
    idx  = '0;
    any  = 1'b0;
    lvl  = '0;
    rank = '0;
    for (int k = 0; k < 8; k++) begin
      idx = 3'(lowp + 3'h1 + 3'(k));
      if (req[idx] && !any) begin
        any  = 1'b1;
        lvl  = idx;
        rank = 3'(k);
      end
    end
  end
endmodule : tli_prio
`default_nettype wire

// ---- src/tli_core.sv ----
// Purpose: twelve level vectored interrupt logic
// Assumes: processor core on the same clock; request pins asynchronous
// Notes:   four direct lines plus an eight level controller
//
// Overview of operation
// - twelve vectored levels in total
// - four top levels go straight to processor
// - direct levels call fixed addresses 24,3c,34,2c
// - trap unmaskable, restart inputs maskable
// - controller serves eight lower levels
// - mode and priority rewritable any time
// - interrupt only if outranking level in service
// - one mask byte, bit per level
// - vectors spaced four or eight bytes
// - block aligned to its own size
// - nested: line 0 highest, 7 lowest
// - rotate: serviced level becomes lowest
// - specific: software names lowest level
// - polled: status register gives requesting level
// - requests from many board sources
// - power fail selectable as request source
`timescale 1ns/1ns
`default_nettype none
module tli_core (
  input  wire logic             mclk,     // board clock
  input  wire logic             rst_n,    // async reset
  input  wire tli_pkg::tli_bus_t bus,     // register port
  output logic [7:0]            rdata_q,  // read data
  input  wire logic [7:0]       irq_in,   // controller request pins
  input  wire logic             trap_in,  // top priority pin
  input  wire logic             r75_in,   // restart 7.5 pin
  input  wire logic             r65_in,   // restart 6.5 pin
  input  wire logic             r55_in,   // restart 5.5 pin
  input  wire logic             ac_low,   // supply power fail
  input  wire tli_pkg::tli_ack_t ack,     // processor acknowledge
  output logic                  cint_q,   // controller interrupt
  output logic [3:0]            dir_q,    // trap,7.5,6.5,5.5 lines
  output tli_pkg::tli_vec_t     vec_q     // vector to processor
);
  import tli_pkg::*;

  localparam int NSYNC = 13; // 8 requests, 4 direct, power fail
  localparam int S_TRAP = 8;
  localparam int S_R75  = 9;
  localparam int S_R65  = 10;
  localparam int S_R55  = 11;
  localparam int S_AC   = 12;

  // every bit of state lives here
  typedef struct packed {
    logic [NSYNC-1:0] sync1;  // first sync stage
    logic [NSYNC-1:0] sync2;  // second sync stage
    logic [7:0]       prev;   // last request level, edge detect
    logic [7:0]       irr;    // pending requests
    logic [7:0]       isr;    // levels in service
    logic [7:0]       mask;   // level mask
    tli_mode_t        mode;   // priority mode
    logic             wide;   // 8-byte spacing
    logic             pfsel;  // power fail onto trap
    logic [15:0]      base;   // vector block base
    logic [2:0]       lowp;   // lowest priority level
    logic [2:0]       dmask;  // restart masks 7.5,6.5,5.5
    logic [7:0]       rdata;  // read data
    logic             cint;   // interrupt request out
    logic [3:0]       dir;    // direct lines out
    tli_vec_t         vec;    // vector out
  } tli_st_t;

  localparam tli_st_t ST_RST = '{mode: TLI_NESTED, lowp: LOWP_RST,
                                 default: '0};

  tli_st_t s_q;  // registered state
  tli_st_t s_d;  // next state

  logic [7:0] req;      // unmasked pending
  logic [2:0] lowp_e;   // lowest level actually used
  logic       r_any;    // request winner present
  logic [2:0] r_lvl;    // request winner
  logic [2:0] r_rank;   // request winner rank
  logic       s_any;    // something in service
  logic [2:0] s_lvl;    // top level in service
  logic [2:0] s_rank;   // its rank
  logic       outrank;  // winner beats in-service level
  logic [15:0] blk;     // aligned block base
  logic [15:0] cvec;    // vector of the winner

  assign req = s_q.irr & ~s_q.mask;

  // nested fixes order
  // nested pins the lowest level at 7, so line 0 ranks first
  assign lowp_e = (s_q.mode == TLI_NESTED) ? LVL_TOP : s_q.lowp;

  // priority from lowp
  // one resolver for requests, one for levels in service
  tli_prio u_req (
    .req  (req),
    .lowp (lowp_e),
    .any  (r_any),
    .lvl  (r_lvl),
    .rank (r_rank)
  );

  tli_prio u_isr (
    .req  (s_q.isr),
    .lowp (lowp_e),
    .any  (s_any),
    .lvl  (s_lvl),
    .rank (s_rank)
  );

  // compare with service
  // an equal rank is the same level and never re-interrupts
  assign outrank = r_any && (!s_any || (r_rank < s_rank));

  // size-aligned block
  // low address bits of the base are ignored, not trapped
  assign blk = s_q.wide ? {s_q.base[15:6], 6'h00}
                        : {s_q.base[15:5], 5'h00};

  assign cvec = s_q.wide ? (blk | {10'h000, r_lvl, 3'h0})
                         : (blk | {11'h000, r_lvl, 2'h0});

  // next-state logic for the whole block
  always_comb begin
    logic [7:0] rise;     // fresh request edges
    logic [7:0] irr_clr;  // pending bits to drop
    logic [7:0] isr_set;  // levels entering service
    logic [7:0] isr_clr;  // levels leaving service
    logic       trap;     // trap with power fail merged
    logic       take;     // controller level taken now
    rise    = '0;
    irr_clr = '0;
    isr_set = '0;
    isr_clr = '0;
    trap    = 1'b0;
    take    = 1'b0;
    s_d     = s_q;

    // request pins synced
    // pins are asynchronous; the first stage feeds only the second
    s_d.sync1 = {ac_low, r55_in, r65_in, r75_in, trap_in, irq_in};
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2[7:0];
    rise      = s_q.sync2[7:0] & ~s_q.prev;

    trap = s_q.sync2[S_TRAP] | (s_q.pfsel & s_q.sync2[S_AC]);
    s_d.dir = {trap,
               s_q.sync2[S_R75] & ~s_q.dmask[2],
               s_q.sync2[S_R65] & ~s_q.dmask[1],
               s_q.sync2[S_R55] & ~s_q.dmask[0]};

    // read data stands for one cycle only
    s_d.rdata   = '0;
    s_d.vec.vld = 1'b0;

    if (ack.stb) begin
      s_d.vec.vld = 1'b1;
      unique case (ack.src)
        ACK_TRAP: s_d.vec.addr = VEC_TRAP;
        ACK_R75:  s_d.vec.addr = VEC_R75;
        ACK_R65:  s_d.vec.addr = VEC_R65;
        ACK_R55:  s_d.vec.addr = VEC_R55;
        ACK_CTL: begin
          // no winner left: answer with the level 7 vector, no service
          if (r_any) begin
            take        = 1'b1;
            s_d.vec.addr = cvec;
          end else begin
            s_d.vec.addr = s_q.wide ? (blk | {10'h000, LVL_TOP, 3'h0})
                                    : (blk | {11'h000, LVL_TOP, 2'h0});
          end
        end
        default: s_d.vec.vld = 1'b0; // unknown source, no answer
      endcase
    end

    // register writes
    if (bus.wr) begin
      unique case (bus.addr)
        REG_CTRL: begin
          s_d.mode  = tli_mode_t'(bus.wdata[CTRL_MODE +: 2]);
          s_d.wide  = bus.wdata[CTRL_WIDE];
          s_d.pfsel = bus.wdata[CTRL_PF];
        end
        REG_MASK:  s_d.mask = bus.wdata;
        REG_BASEL: s_d.base[7:0] = bus.wdata;
        REG_BASEH: s_d.base[15:8] = bus.wdata;
        REG_LOWP:  s_d.lowp = bus.wdata[2:0];
        REG_DMASK: s_d.dmask = bus.wdata[2:0];
        REG_EOI: begin
          if (s_any) begin
            isr_clr[s_lvl] = 1'b1;
            if (s_q.mode == TLI_ROTATE) s_d.lowp = s_lvl;
          end
        end
        default: ; // read-only or unmapped: write ignored
      endcase
    end

    // register reads, answered one cycle later
    if (bus.rd) begin
      unique case (bus.addr)
        REG_CTRL:  s_d.rdata = {4'h0, s_q.pfsel, s_q.wide, s_q.mode};
        REG_MASK:  s_d.rdata = s_q.mask;
        REG_BASEL: s_d.rdata = s_q.base[7:0];
        REG_BASEH: s_d.rdata = s_q.base[15:8];
        REG_LOWP:  s_d.rdata = {5'h00, s_q.lowp};
        REG_DMASK: s_d.rdata = {5'h00, s_q.dmask};
        REG_INSV:  s_d.rdata = s_q.isr;
        REG_PEND:  s_d.rdata = s_q.irr;
        // poll status read
        // in polled mode the read also serves as acknowledge
        REG_POLL: begin
          s_d.rdata = {r_any, 4'h0, r_lvl};
          if (s_q.mode == TLI_POLLED && r_any) take = 1'b1;
        end
        default: s_d.rdata = '0; // unmapped reads zero
      endcase
    end

    // taking a level moves it from pending to in service
    if (take) begin
      irr_clr[r_lvl] = 1'b1;
      isr_set[r_lvl] = 1'b1;
    end

    // pending until taken
    // a new edge wins over the clear; a mask drops the request
    s_d.irr = ((s_q.irr & ~irr_clr) | rise) & ~s_d.mask;
    // a level entering service wins over an end of service
    s_d.isr = (s_q.isr & ~isr_clr) | isr_set;

    // controller interrupt line
    // dropped on acknowledge so one request gives one interrupt
    s_d.cint = outrank && (s_q.mode != TLI_POLLED) &&
               !(ack.stb && ack.src == ACK_CTL);
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_q = s_q.rdata;
  assign cint_q  = s_q.cint;
  assign dir_q   = s_q.dir;
  assign vec_q   = s_q.vec;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  trap_unmasked_a: assert property (
    s_q.sync2[S_TRAP] |=> dir_q[3])
    else $error("trap level not forwarded");

  r75_masked_a: assert property (
    s_q.dmask[2] && !bus.wr |=> !dir_q[2])
    else $error("masked restart 7.5 forwarded");

  trap_vector_a: assert property (
    ack.stb && ack.src == ACK_TRAP |=> vec_q.vld && vec_q.addr == VEC_TRAP)
    else $error("trap vector wrong");

  r55_vector_a: assert property (
    ack.stb && ack.src == ACK_R55 |=> vec_q.vld && vec_q.addr == VEC_R55)
    else $error("restart 5.5 vector wrong");

  polled_quiet_a: assert property (
    s_q.mode == TLI_POLLED |=> !cint_q)
    else $error("interrupt raised in polled mode");

  int_cause_a: assert property (
    cint_q |-> $past(outrank))
    else $error("interrupt without outranking request");

  mask_drop_a: assert property (
    s_q.mask[0] && !bus.wr ##1 !bus.wr |=> !s_q.irr[0])
    else $error("masked level still pending");

  nested_top_a: assert property (
    s_q.mode == TLI_NESTED && req[0] && ack.stb && ack.src == ACK_CTL
    |=> vec_q.addr == $past(blk) && s_q.isr[0])
    else $error("level 0 not first in nested mode");

  spacing_a: assert property (
    ack.stb && ack.src == ACK_CTL && s_q.wide && !bus.wr
    |=> vec_q.addr[2:0] == 3'h0)
    else $error("vector not on 8-byte spacing");

  rotate_sink_a: assert property (
    s_q.mode == TLI_ROTATE && bus.wr && bus.addr == REG_EOI && s_any
    |=> s_q.lowp == $past(s_lvl))
    else $error("serviced level did not become lowest");

  eoi_release_a: assert property (
    bus.wr && bus.addr == REG_EOI && s_any && !ack.stb
    |=> !s_q.isr[$past(s_lvl)])
    else $error("end of service left level in service");

  pf_trap_a: assert property (
    s_q.pfsel && s_q.sync2[S_AC] |=> dir_q[3])
    else $error("power fail not routed onto trap");

  pend_hold_a: assert property (
    s_q.irr[4] && !ack.stb && !bus.rd && !bus.wr |=> s_q.irr[4])
    else $error("pending level dropped before acknowledge");

  block_align_a: assert property (
    ack.stb && ack.src == ACK_CTL && !s_q.wide
    |=> vec_q.addr[15:5] == $past(s_q.base[15:5]))
    else $error("vector outside its 32-byte block");

  cint_drop_a: assert property (
    ack.stb && ack.src == ACK_CTL |=> !cint_q)
    else $error("interrupt line held after acknowledge");

  poll_take_a: assert property (
    s_q.mode == TLI_POLLED && bus.rd && bus.addr == REG_POLL && r_any
    |=> s_q.isr[$past(r_lvl)])
    else $error("polled level not put in service");

  mode_write_a: assert property (
    bus.wr && bus.addr == REG_CTRL
    |=> s_q.mode == tli_mode_t'($past(bus.wdata[CTRL_MODE +: 2])))
    else $error("mode write did not take effect");

  ctl_ack_c: cover property (
    cint_q ##[1:4] (ack.stb && ack.src == ACK_CTL) ##1 vec_q.vld);
  rotate_eoi_c: cover property (
    s_q.mode == TLI_ROTATE && bus.wr && bus.addr == REG_EOI && s_any);
  poll_read_c: cover property (
    s_q.mode == TLI_POLLED && bus.rd && bus.addr == REG_POLL && r_any);
  specific_ack_c: cover property (
    s_q.mode == TLI_SPECIFIC && ack.stb && ack.src == ACK_CTL && r_any);
  wide_vec_c: cover property (
    s_q.wide && vec_q.vld);
endmodule : tli_core
`default_nettype wire

// ---- verif/tli_cpu_model.sv ----
// Purpose: processor side model that answers the interrupt lines
// Assumes: one acknowledge at a time, strongest line first
// Notes:   dly inserts wait states so slow answers are exercised too
`timescale 1ns/1ns
`default_nettype none
module tli_cpu_model (
  input  wire logic              mclk,      // board clock
  input  wire logic              rst_n,     // async reset, low
  input  wire logic              en,        // answer only while high
  input  wire logic [3:0]        dly,       // cycles before acknowledge
  input  wire logic              cint_q,    // controller interrupt
  input  wire logic [3:0]        dir_q,     // direct lines
  input  wire tli_pkg::tli_vec_t vec_q,     // vector handed back
  output tli_pkg::tli_ack_t      ack,       // acknowledge to the logic
  output logic [15:0]            got_addr,  // last vector taken
  output int                     n_vec      // vectors taken so far
);
  import tli_pkg::*;
  logic [2:0] src;  // line being answered
  int         i;    // bounded wait counter
  // one acknowledge per request; a line held over 40 cycles is answered again
  // a single process drives every output, so none has two drivers
  initial begin
    ack      = '0;
    got_addr = '0;
    n_vec    = 0;
    forever begin
      @(posedge mclk);
      if (rst_n && en && (cint_q || dir_q != 4'h0)) begin
        repeat (dly) @(posedge mclk);
        src = dir_q[3] ? ACK_TRAP : dir_q[2] ? ACK_R75 :
              dir_q[1] ? ACK_R65 : dir_q[0] ? ACK_R55 : ACK_CTL;
        ack <= '{stb: 1'b1, src: src};
        @(posedge mclk);
        ack <= '0;
        // vector taken only after the acknowledge
        for (i = 0; i < 4 && vec_q.vld !== 1'b1; i++) @(negedge mclk);
        if (vec_q.vld === 1'b1) begin
          got_addr = vec_q.addr;
          n_vec++;
        end
        // wait for the answered line to fall, else it is taken twice
        for (i = 0; i < 40 && ((src == ACK_CTL) ? cint_q :
             dir_q[2'd3 - src[1:0]]) === 1'b1; i++) @(posedge mclk);
      end
    end
  end
endmodule : tli_cpu_model
`default_nettype wire

// ---- verif/tli_core_tb_top.sv ----
// Purpose: self-checking bench of the twelve level interrupt logic
// Assumes: processor model answers every line while enabled
// Notes:   vectors are worked out here from base, level and spacing
`timescale 1ns/1ns
`default_nettype none
module tli_core_tb_top;
  import tli_pkg::*;
  localparam logic [15:0] BASE = 16'h1234; // misaligned on purpose
  logic        mclk;            // board clock
  logic        rst_n;           // async reset
  tli_bus_t    bus;             // register port
  logic [7:0]  rdata_q;         // read data
  logic [7:0]  irq;             // controller pins
  logic [3:0]  dpin;            // trap, 7.5, 6.5, 5.5 pins
  logic        ac_low;          // supply power fail
  tli_ack_t    ack;             // from the model
  logic        cint_q;          // controller interrupt
  logic [3:0]  dir_q;           // direct lines
  tli_vec_t    vec_q;           // vector out
  logic        en;              // model answers
  logic [3:0]  dly;             // model wait states
  logic [15:0] got_addr;        // vector the model took
  int          n_vec;           // vectors the model took
  int          nv = 0;          // vectors already checked
  int          n_errors = 0;    // mismatches
  int          num_checks = 0;  // comparisons
  int          cyc = 0;         // cycles run
  tli_core uut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata_q(rdata_q),
    .irq_in(irq), .trap_in(dpin[3]), .r75_in(dpin[2]), .r65_in(dpin[1]),
    .r55_in(dpin[0]), .ac_low(ac_low), .ack(ack), .cint_q(cint_q),
    .dir_q(dir_q), .vec_q(vec_q));
  tli_cpu_model cpu (.mclk(mclk), .rst_n(rst_n), .en(en), .dly(dly),
    .cint_q(cint_q), .dir_q(dir_q), .vec_q(vec_q), .ack(ack),
    .got_addr(got_addr), .n_vec(n_vec));
  // free running clock, 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // hang guard: far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one cycle write strobe, released at the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    @(negedge mclk);
    chk(what, {8'h00, rdata_q}, {8'h00, exp});
  endtask : rd
  task automatic wait_vec(input logic [15:0] exp);
    int i;
    for (i = 0; i < 60 && n_vec == nv; i++) @(negedge mclk);
    chk("vector taken", {15'h0, n_vec != nv}, 16'h0001);
    nv = n_vec;
    chk("vector", got_addr, exp);
  endtask : wait_vec
  task automatic pins(input logic [7:0] v);
    @(posedge mclk);
    irq <= v;
  endtask : pins
  // two requests at once: winner first, the other after end of service
  task automatic pair(input logic [7:0] ctrl, input int lp,
                      input int l1, input int l2);
    logic [15:0] al;
    int          sh;
    al = ctrl[CTRL_WIDE] ? (BASE & 16'hffc0) : (BASE & 16'hffe0);
    sh = ctrl[CTRL_WIDE] ? 3 : 2;
    wr(REG_CTRL, ctrl);
    if (lp >= 0) wr(REG_LOWP, 8'(lp));
    pins(8'(1 << l1) | 8'(1 << l2));
    wait_vec(al | 16'(l1 << sh));
    pins(8'h00);
    repeat (8) @(posedge mclk);
    chk("cint", {15'h0, cint_q}, 16'h0);
    rd(REG_PEND, 8'(1 << l2), "pend");
    rd(REG_INSV, 8'(1 << l1), "insv");
    wr(REG_EOI, 8'h00);
    wait_vec(al | 16'(l2 << sh));
    wr(REG_EOI, 8'h00);
    rd(REG_INSV, 8'h00, "insv");
  endtask : pair
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  initial begin
    bus = '0; irq = 8'h00; dpin = 4'h0; ac_low = 1'b0;
    en = 1'b0; dly = 4'h0; rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    // reset state, read-only and unmapped places
    rd(REG_LOWP, 8'h07, "lowp");
    rd(REG_MASK, 8'h00, "mask");
    wr(REG_INSV, 8'hff);
    rd(REG_INSV, 8'h00, "insv");
    rd(4'hf, 8'h00, "unmapped");
    wr(REG_BASEL, BASE[7:0]);
    wr(REG_BASEH, BASE[15:8]);
    rd(REG_BASEH, BASE[15:8], "base");
    rd(REG_BASEL, BASE[7:0], "base");
    $display("test registers done");
    // all direct lines at once, strongest answered first
    pins(8'h00);
    dpin <= 4'hf;
    repeat (6) @(posedge mclk);
    en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wait_vec(k == 0 ? VEC_TRAP : k == 1 ? VEC_R75 :
               k == 2 ? VEC_R65 : VEC_R55);
      @(posedge mclk);
      dpin[3 - k] <= 1'b0;
    end
    wr(REG_DMASK, 8'h07);
    en <= 1'b0;
    dpin <= 4'hf;
    repeat (6) @(posedge mclk);
    chk("dir", {12'h0, dir_q}, 16'h0008);
    dpin <= 4'h0;
    rd(REG_DMASK, 8'h07, "dmask");
    wr(REG_DMASK, 8'h00);
    // power fail reaches trap only when selected
    ac_low <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("dir", {12'h0, dir_q}, 16'h0000);
    wr(REG_CTRL, 8'h08);
    repeat (6) @(posedge mclk);
    chk("dir", {12'h0, dir_q}, 16'h0008);
    ac_low <= 1'b0;
    rd(REG_CTRL, 8'h08, "ctrl");
    wr(REG_CTRL, 8'h00);
    repeat (6) @(posedge mclk);
    $display("test direct lines done");
    // masked line ignored, open one held until answered
    wr(REG_MASK, 8'h09);
    pins(8'h19);
    repeat (20) @(posedge mclk);
    chk("cint", {15'h0, cint_q}, 16'h1);
    rd(REG_PEND, 8'h10, "pend");
    pins(8'h00);
    en <= 1'b1;
    wait_vec((BASE & 16'hffe0) | 16'h0010);
    wr(REG_EOI, 8'h00);
    wr(REG_MASK, 8'h00);
    // every controller line, answered fast and slow
    for (int l = 0; l < 8; l++) begin
      dly <= 4'(l);
      pins(8'(1 << l));
      wait_vec((BASE & 16'hffe0) | 16'(l << 2));
      pins(8'h00);
      wr(REG_EOI, 8'h00);
    end
    dly <= 4'h0;
    $display("test controller lines done");
    // nested ignores the lowest level register
    pair(8'h00, 3, 2, 5);
    pair(8'h04, -1, 0, 7);
    // rotate: a served level drops to the bottom; specific: software names it
    pair(8'h01, 7, 0, 1);
    rd(REG_LOWP, 8'h01, "lowp");
    pair(8'h01, -1, 2, 1);
    pair(8'h02, 3, 5, 2);
    $display("test priority modes done");
    // polled status read instead of an interrupt
    wr(REG_CTRL, 8'h03);
    pins(8'h40);
    repeat (8) @(posedge mclk);
    chk("cint", {15'h0, cint_q}, 16'h0);
    rd(REG_POLL, 8'h86, "poll");
    rd(REG_INSV, 8'h40, "insv");
    pins(8'h00);
    wr(REG_EOI, 8'h00);
    $display("test polled done");
    final_report();
  end
endmodule : tli_core_tb_top
`default_nettype wire
